// [verilog/mdp_pkg.sv]
package mdp_pkg;

   // Decode and general logic input count, window geometry
   localparam int DEC_INPUTS     = 69;
   localparam int DEC_PAD        = 4;
   localparam int WINDOW_SIZE    = 256;
   localparam int CTRL_REG_COUNT = 39;
   localparam int PT_MAX         = 10;
   localparam int NUM_OMC        = 16;
   localparam int BANK_SIZE      = 8;
   localparam int NUM_IMC        = 20;
   localparam int MAIN_SECTORS   = 8;
   localparam int SEC_SECTORS    = 4;
   localparam int NUM_PERIPH     = 2;
   localparam int NUM_EXT_CS     = 2;
   localparam int PORT_C_GEN     = 4;
   localparam int PORT_D_PINS    = 2;
   localparam int JTAG_PINS      = 4;

   // Control window offsets
   localparam logic [7:0] OFF_IN_A     = 8'h00;
   localparam logic [7:0] OFF_IN_B     = 8'h01;
   localparam logic [7:0] OFF_OUT_A    = 8'h04;
   localparam logic [7:0] OFF_OUT_B    = 8'h05;
   localparam logic [7:0] OFF_DIR_A    = 8'h06;
   localparam logic [7:0] OFF_DIR_B    = 8'h07;
   localparam logic [7:0] OFF_IMC_A    = 8'h0A;
   localparam logic [7:0] OFF_IMC_B    = 8'h0B;
   localparam logic [7:0] OFF_IN_C     = 8'h10;
   localparam logic [7:0] OFF_IN_D     = 8'h11;
   localparam logic [7:0] OFF_OUT_C    = 8'h12;
   localparam logic [7:0] OFF_OUT_D    = 8'h13;
   localparam logic [7:0] OFF_DIR_C    = 8'h14;
   localparam logic [7:0] OFF_DIR_D    = 8'h15;
   localparam logic [7:0] OFF_IMC_C    = 8'h18;
   localparam logic [7:0] OFF_OMC_LOW  = 8'h20;
   localparam logic [7:0] OFF_OMC_HIGH = 8'h21;
   localparam logic [7:0] OFF_POWER    = 8'hB0;
   localparam logic [7:0] OFF_PAGE     = 8'hE0;

   // Reset values and field positions
   localparam logic [7:0] PAGE_RESET   = 8'h00;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam logic       LOWPWR_RESET = 1'b0;
   localparam int         POWER_LOWPWR_BIT = 1;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        rd;
      logic        wr;
      logic        fetch;
   } mdp_bus_s;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [3:0] c;
      logic [1:0] d;
   } mdp_pins_s;

   typedef struct packed {
      logic [7:0] main_sector_selects;
      logic [3:0] secondary_sector_selects;
      logic       sram_select;
      logic       ctrl_window_select;
      logic       peripheral_window_select_1;
      logic       peripheral_window_select_0;
      logic [1:0] ext_chip_select;
   } mdp_sel_s;

endpackage

// [verilog/mdp_out_macrocell.sv]
`timescale 1ns/1ps
`default_nettype none
module mdp_out_macrocell #(
   parameter int                 IN         = 69,
   parameter int                 PT         = 10,
   parameter logic [PT*IN-1:0]   TRUE_MASK  = '0,
   parameter logic [PT*IN-1:0]   COMP_MASK  = '0,
   parameter logic [PT-1:0]      PT_EN      = '0,
   parameter logic               REGISTERED = 1'b1
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic [IN-1:0] terms,
   input  wire logic          load,
   input  wire logic          load_value,
   output logic               q,
   output logic               out
);
   typedef struct packed {
      logic q;
   } mdp_omc_s;

   mdp_omc_s   s;
   mdp_omc_s   next_s;
   logic [PT-1:0] pterm;
   logic          sum;

   // Each product term ANDs selected true and complement inputs
   for (genvar j = 0; j < PT; j++) begin : g_pt
      assign pterm[j] = PT_EN[j]
                      & (&((terms | ~TRUE_MASK[j*IN +: IN]) & (~terms | ~COMP_MASK[j*IN +: IN])));
   end
   assign sum = |pterm;

   always_comb begin
      next_s = s;
      // Processor load beats the logic in the same cycle
      if (load) begin
         next_s.q = load_value;
      end else if (REGISTERED) begin
         next_s.q = sum;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q   = s.q;
   assign out = REGISTERED ? s.q : sum;
endmodule
`default_nettype wire

// [verilog/mdp_decode.sv]
// Behaviour
// - One SRAM select, raised for data reads or writes inside the SRAM range.
// - A 256-byte control window has its own select from the decode logic.
// - Control window answers data strobes only, never the program fetch strobe.
// - Control registers are chosen by offset from the window base address.
// - Control registers in the window cover ports, page, power and macrocells.
// - Eight-bit page register, written and read back by the processor.
// - Page bits feed both logic arrays as extended address lines.
// - Spare page bits are ordinary general logic inputs.
// - Page register clears to zero at reset.
// - Low-power mode lets the arrays idle while their inputs stay still.
// - Logic configuration is fixed; the processor cannot change it.
// - At most one memory or control window select per presented address; peripheral and chip selects are decoded independently.
// - Decode logic may drive external chip selects on port D.
// - Two peripheral selects; while either is active port A repeats data.
// - Decode logic takes 69 inputs: bus, page, pins and feedback.
// - Sixteen output macrocells in two banks of eight, twenty input macrocells.
// - Processor loads and reads every output macrocell flop directly.
// - Each output macrocell ORs up to ten terms, combinational or registered.
// - Low bank routes to port A or B, high bank to B or C.
// - Input macrocells clock or pass pins; processor reads them anytime.
// - JTAG pins go straight to test logic, bypassing input macrocells.
// - Low-power bit resets to zero, so arrays start fast.
`timescale 1ns/1ps
`default_nettype none
module mdp_decode #(
   parameter logic [15:0]  SRAM_BASE    = 16'h0000,
   parameter logic [15:0]  SRAM_LIMIT   = 16'h1FFF,
   parameter logic [15:0]  CTRL_BASE    = 16'h2000,
   parameter logic [127:0] MAIN_BASE    = '0,
   parameter logic [127:0] MAIN_LIMIT   = {8{16'hFFFF}},
   parameter logic [63:0]  MAIN_PAGE    = '0,
   parameter logic [7:0]   MAIN_PAGED   = 8'h00,
   parameter logic [7:0]   MAIN_DATA    = 8'h00,
   parameter logic [7:0]   MAIN_EN      = 8'h01,
   parameter logic [63:0]  SEC_BASE     = '0,
   parameter logic [63:0]  SEC_LIMIT    = '0,
   parameter logic [3:0]   SEC_DATA     = 4'h0,
   parameter logic [3:0]   SEC_EN       = 4'h0,
   parameter logic [31:0]  PERIPH_BASE  = '0,
   parameter logic [31:0]  PERIPH_LIMIT = '0,
   parameter logic [1:0]   PERIPH_EN    = 2'b00,
   parameter logic [31:0]  EXT_CS_BASE  = '0,
   parameter logic [31:0]  EXT_CS_LIMIT = '0,
   parameter logic [1:0]   EXT_CS_EN    = 2'b00,
   parameter logic [7:0]   LOW_ON_A     = 8'h00,
   parameter logic [7:0]   LOW_ON_B     = 8'h00,
   parameter logic [7:0]   HIGH_ON_B    = 8'h00,
   parameter logic [3:0]   HIGH_ON_C    = 4'h0,
   parameter logic [19:0]  IMC_CLOCKED  = {20{1'b1}},
   parameter int           PT           = 10,
   parameter logic [16*PT*69-1:0] OMC_TRUE  = '0,
   parameter logic [16*PT*69-1:0] OMC_COMP  = '0,
   parameter logic [16*PT-1:0]    OMC_PT_EN = '0,
   parameter logic [15:0]  OMC_REGISTERED = 16'hFFFF
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire mdp_pkg::mdp_bus_s   bus,
   input  wire mdp_pkg::mdp_pins_s  pin_in,
   input  wire logic [3:0]          jtag_pins,
   output logic [3:0]               jtag_to_test,
   output logic [7:0]               rdata,
   output logic                     rvalid,
   output mdp_pkg::mdp_sel_s        sel,
   output mdp_pkg::mdp_pins_s       pin_out,
   output mdp_pkg::mdp_pins_s       pin_oe,
   output logic [7:0]               page_lines,
   output logic                     low_power,
   output logic                     array_standby
);
   localparam int IN = mdp_pkg::DEC_INPUTS;

   typedef struct packed {
      logic [7:0]          page;
      logic                low_power;
      mdp_pkg::mdp_pins_s  out;
      mdp_pkg::mdp_pins_s  dir;
      logic [7:0]          imc_a;
      logic [7:0]          imc_b;
      logic [3:0]          imc_c;
      logic [7:0]          rdata;
      logic                rvalid;
      logic [IN-1:0]       prev_in;
      logic                standby;
      mdp_pkg::mdp_pins_s  pout;
      mdp_pkg::mdp_pins_s  poe;
   } mdp_state_s;

   mdp_state_s s;
   mdp_state_s next_s;

   logic [IN-1:0]  dec_in;
   logic [7:0]     main_hit;
   logic [3:0]     sec_hit;
   logic [1:0]     periph_hit;
   logic [1:0]     cs_hit;
   logic           data_acc;
   logic           sram_hit;
   logic           ctrl_hit;
   logic [15:0]    ctrl_top;
   logic [7:0]     offset;
   logic           ctrl_wr;
   logic           ctrl_rd;
   logic           periph_on;
   logic [15:0]    omc_q;
   logic [15:0]    omc_out;
   logic [15:0]    omc_load;
   logic [7:0]     main_first;
   logic [3:0]     sec_first;
   logic [19:0]    imc_now;

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // Bus, page, pins and feedback form the shared term vector
   assign dec_in = {{mdp_pkg::DEC_PAD{1'b0}}, omc_out, pin_in, s.page,
                    bus.fetch, bus.wr, bus.rd, bus.addr};
   assign data_acc = bus.rd | bus.wr;
   assign ctrl_top = CTRL_BASE + 16'(mdp_pkg::WINDOW_SIZE - 1);
   assign ctrl_hit = data_acc & in_range(bus.addr, CTRL_BASE, ctrl_top);
   assign sram_hit = data_acc & in_range(bus.addr, SRAM_BASE, SRAM_LIMIT);
   assign offset   = 8'(bus.addr - CTRL_BASE);

   for (genvar i = 0; i < mdp_pkg::MAIN_SECTORS; i++) begin : g_main
      assign main_hit[i] = MAIN_EN[i]
                         & in_range(bus.addr, MAIN_BASE[i*16 +: 16], MAIN_LIMIT[i*16 +: 16])
                         & (~MAIN_PAGED[i] | (s.page == MAIN_PAGE[i*8 +: 8]))
                         & (MAIN_DATA[i] ? data_acc : bus.fetch);
   end
   for (genvar i = 0; i < mdp_pkg::SEC_SECTORS; i++) begin : g_sec
      assign sec_hit[i] = SEC_EN[i]
                        & in_range(bus.addr, SEC_BASE[i*16 +: 16], SEC_LIMIT[i*16 +: 16])
                        & (SEC_DATA[i] ? data_acc : bus.fetch);
   end
   for (genvar i = 0; i < mdp_pkg::NUM_PERIPH; i++) begin : g_periph
      assign periph_hit[i] = PERIPH_EN[i] & data_acc
                           & in_range(bus.addr, PERIPH_BASE[i*16 +: 16], PERIPH_LIMIT[i*16 +: 16]);
      assign cs_hit[i] = EXT_CS_EN[i]
                       & in_range(bus.addr, EXT_CS_BASE[i*16 +: 16], EXT_CS_LIMIT[i*16 +: 16]);
   end

   // Overlapping ranges resolve by fixed priority instead of double-driving memory
   assign main_first = main_hit & (~main_hit + 8'h01);
   assign sec_first  = sec_hit & (~sec_hit + 4'h1);

   always_comb begin
      sel = '0;
      if (ctrl_hit) begin
         sel.ctrl_window_select = 1'b1;
      end else if (sram_hit) begin
         sel.sram_select = 1'b1;
      end else if (|main_hit) begin
         sel.main_sector_selects = main_first;
      end else begin
         sel.secondary_sector_selects = sec_first;
      end
      sel.peripheral_window_select_0 = periph_hit[0];
      sel.peripheral_window_select_1 = periph_hit[1];
      sel.ext_chip_select = cs_hit;
   end

   assign ctrl_wr   = sel.ctrl_window_select & bus.wr;
   assign ctrl_rd   = sel.ctrl_window_select & bus.rd;
   assign periph_on = |periph_hit;

   // Logic masks are elaboration constants; no write path reaches them
   for (genvar k = 0; k < mdp_pkg::NUM_OMC; k++) begin : g_omc
      assign omc_load[k] = ctrl_wr & (offset == ((k < mdp_pkg::BANK_SIZE)
                         ? mdp_pkg::OFF_OMC_LOW : mdp_pkg::OFF_OMC_HIGH));
      mdp_out_macrocell #(
         .IN         (IN),
         .PT         (PT),
         .TRUE_MASK  (OMC_TRUE[k*PT*IN +: PT*IN]),
         .COMP_MASK  (OMC_COMP[k*PT*IN +: PT*IN]),
         .PT_EN      (OMC_PT_EN[k*PT +: PT]),
         .REGISTERED (OMC_REGISTERED[k])
      ) u_omc (
         .clk        (clk),
         .rst        (rst),
         .terms      (dec_in),
         .load       (omc_load[k]),
         .load_value (bus.wdata[k % mdp_pkg::BANK_SIZE]),
         .q          (omc_q[k]),
         .out        (omc_out[k])
      );
   end

   // Input macrocells: clocked copy or straight pin value
   for (genvar m = 0; m < mdp_pkg::NUM_IMC; m++) begin : g_imc
      assign imc_now[m] = IMC_CLOCKED[m]
                        ? (m < 8 ? s.imc_a[m % 8] : (m < 16 ? s.imc_b[m % 8] : s.imc_c[m % 4]))
                        : (m < 8 ? pin_in.a[m % 8] : (m < 16 ? pin_in.b[m % 8]
                                                              : pin_in.c[m % 4]));
   end

   // Test pins never pass through input macrocells
   assign jtag_to_test = jtag_pins;

   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.imc_a = pin_in.a;
      next_s.imc_b = pin_in.b;
      next_s.imc_c = pin_in.c;
      next_s.prev_in = dec_in;
      // Standby only when the inputs held still across a full cycle
      next_s.standby = s.low_power & (dec_in == s.prev_in);
      if (ctrl_wr) begin
         case (offset)
            mdp_pkg::OFF_PAGE:  next_s.page = bus.wdata;
            mdp_pkg::OFF_POWER: next_s.low_power = bus.wdata[mdp_pkg::POWER_LOWPWR_BIT];
            mdp_pkg::OFF_OUT_A: next_s.out.a = bus.wdata;
            mdp_pkg::OFF_OUT_B: next_s.out.b = bus.wdata;
            mdp_pkg::OFF_OUT_C: next_s.out.c = bus.wdata[3:0];
            mdp_pkg::OFF_OUT_D: next_s.out.d = bus.wdata[1:0];
            mdp_pkg::OFF_DIR_A: next_s.dir.a = bus.wdata;
            mdp_pkg::OFF_DIR_B: next_s.dir.b = bus.wdata;
            mdp_pkg::OFF_DIR_C: next_s.dir.c = bus.wdata[3:0];
            mdp_pkg::OFF_DIR_D: next_s.dir.d = bus.wdata[1:0];
            default: ;
         endcase
      end
      if (ctrl_rd) begin
         next_s.rvalid = 1'b1;
         case (offset)
            mdp_pkg::OFF_PAGE:     next_s.rdata = s.page;
            mdp_pkg::OFF_POWER:    next_s.rdata = 8'({s.low_power, 1'b0});
            mdp_pkg::OFF_IN_A:     next_s.rdata = pin_in.a;
            mdp_pkg::OFF_IN_B:     next_s.rdata = pin_in.b;
            mdp_pkg::OFF_IN_C:     next_s.rdata = 8'(pin_in.c);
            mdp_pkg::OFF_IN_D:     next_s.rdata = 8'(pin_in.d);
            mdp_pkg::OFF_OUT_A:    next_s.rdata = s.out.a;
            mdp_pkg::OFF_OUT_B:    next_s.rdata = s.out.b;
            mdp_pkg::OFF_OUT_C:    next_s.rdata = 8'(s.out.c);
            mdp_pkg::OFF_OUT_D:    next_s.rdata = 8'(s.out.d);
            mdp_pkg::OFF_DIR_A:    next_s.rdata = s.dir.a;
            mdp_pkg::OFF_DIR_B:    next_s.rdata = s.dir.b;
            mdp_pkg::OFF_DIR_C:    next_s.rdata = 8'(s.dir.c);
            mdp_pkg::OFF_DIR_D:    next_s.rdata = 8'(s.dir.d);
            mdp_pkg::OFF_IMC_A:    next_s.rdata = imc_now[7:0];
            mdp_pkg::OFF_IMC_B:    next_s.rdata = imc_now[15:8];
            mdp_pkg::OFF_IMC_C:    next_s.rdata = 8'(imc_now[19:16]);
            mdp_pkg::OFF_OMC_LOW:  next_s.rdata = omc_q[7:0];
            mdp_pkg::OFF_OMC_HIGH: next_s.rdata = omc_q[15:8];
            default:               next_s.rdata = mdp_pkg::REG_RESET;
         endcase
      end else if (periph_on & bus.rd) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = pin_in.a;
      end
      // Pin routing; the repeater owns port A while a peripheral window is hit
      for (int i = 0; i < mdp_pkg::BANK_SIZE; i++) begin
         if (periph_on) begin
            next_s.pout.a[i] = bus.wdata[i];
            next_s.poe.a[i] = bus.wr;
         end else if (LOW_ON_A[i]) begin
            next_s.pout.a[i] = omc_out[i];
            next_s.poe.a[i] = 1'b1;
         end else begin
            next_s.pout.a[i] = s.out.a[i];
            next_s.poe.a[i] = s.dir.a[i];
         end
         if (LOW_ON_B[i]) begin
            next_s.pout.b[i] = omc_out[i];
            next_s.poe.b[i] = 1'b1;
         end else if (HIGH_ON_B[i]) begin
            next_s.pout.b[i] = omc_out[i + mdp_pkg::BANK_SIZE];
            next_s.poe.b[i] = 1'b1;
         end else begin
            next_s.pout.b[i] = s.out.b[i];
            next_s.poe.b[i] = s.dir.b[i];
         end
      end
      for (int i = 0; i < mdp_pkg::PORT_C_GEN; i++) begin
         next_s.pout.c[i] = HIGH_ON_C[i] ? omc_out[i + mdp_pkg::BANK_SIZE] : s.out.c[i];
         next_s.poe.c[i] = HIGH_ON_C[i] | s.dir.c[i];
      end
      for (int i = 0; i < mdp_pkg::PORT_D_PINS; i++) begin
         next_s.pout.d[i] = EXT_CS_EN[i] ? cs_hit[i] : s.out.d[i];
         next_s.poe.d[i] = EXT_CS_EN[i] | s.dir.d[i];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.page <= mdp_pkg::PAGE_RESET;
         s.low_power <= mdp_pkg::LOWPWR_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign rdata         = s.rdata;
   assign rvalid        = s.rvalid;
   assign pin_out       = s.pout;
   assign pin_oe        = s.poe;
   assign page_lines    = s.page;
   assign low_power     = s.low_power;
   assign array_standby = s.standby;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence page_write_s;
      ctrl_wr && offset == mdp_pkg::OFF_PAGE;
   endsequence
   sequence page_read_s;
      ctrl_rd && offset == mdp_pkg::OFF_PAGE;
   endsequence

   page_reset_a: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> page_lines == mdp_pkg::PAGE_RESET && !low_power)
      else $error("page or power bit not cleared");
   page_store_a: assert property (page_write_s ##1 page_read_s |=>
      rvalid && rdata == $past(bus.wdata, 2)) else $error("page readback mismatch");
   page_hold_a: assert property (!page_write_s |=> $stable(page_lines))
      else $error("page changed without a write");
   select_one_a: assert property ($onehot0({sel.main_sector_selects,
      sel.secondary_sector_selects, sel.sram_select, sel.ctrl_window_select}))
      else $error("more than one select");
   ctrl_fetch_a: assert property (bus.fetch && !bus.rd && !bus.wr |->
      !sel.ctrl_window_select) else $error("window selected by fetch");
   ctrl_span_a: assert property (sel.ctrl_window_select |->
      16'(bus.addr - CTRL_BASE) < mdp_pkg::WINDOW_SIZE)
      else $error("window select outside 256 bytes");
   sram_sel_a: assert property (sram_hit && !ctrl_hit |-> sel.sram_select)
      else $error("sram not selected");
   omc_load_a: assert property (ctrl_wr && offset == mdp_pkg::OFF_OMC_LOW |=>
      omc_q[7:0] == $past(bus.wdata)) else $error("low bank load failed");
   repeat_a: assert property (periph_on && bus.wr |=>
      pin_oe.a == 8'hFF && pin_out.a == $past(bus.wdata)) else $error("repeater idle");
   standby_a: assert property ((low_power && $stable(dec_in)) [*2] |=> array_standby)
      else $error("standby not entered");
   fast_a: assert property (!low_power |=> !array_standby)
      else $error("standby while in fast mode");
endmodule
`default_nettype wire

// [test/mdp_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mdp_cpu_model (
   input  wire logic               clk,
   output var  mdp_pkg::mdp_bus_s  bus,
   input  wire logic [7:0]         rdata,
   input  wire logic               rvalid
);
   initial bus = '0;

   // Raise one request; it is taken at the next edge
   task automatic put(input logic [15:0] a, input logic [7:0] d,
                      input logic r, input logic w, input logic f);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, rd: r, wr: w, fetch: f};
   endtask

   // Released lines show inverted junk, not the last value
   task automatic rel();
      @(posedge clk);
      bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, rd: 1'b0, wr: 1'b0, fetch: 1'b0};
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] q, output logic v);
      put(a, 8'h00, 1'b1, 1'b0, 1'b0);
      rel();
      #1;
      v = rvalid;
      q = rdata;
   endtask

   // Back-to-back write then read of the same place
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
      put(a, d, 1'b0, 1'b1, 1'b0);
      put(a, ~d, 1'b1, 1'b0, 1'b0);
      rel();
      #1;
      v = rvalid;
      q = rdata;
   endtask

   // Only implemented offsets are ever addressed by the callers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      put(a, d, 1'b0, 1'b1, 1'b0);
      rel();
   endtask
endmodule
`default_nettype wire

// [test/tb_memory_decode_and_page_control.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_memory_decode_and_page_control;
   localparam logic [15:0] CB = 16'h2000;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   mdp_pkg::mdp_bus_s   bus;
   mdp_pkg::mdp_pins_s  pin_in = '0;
   logic [3:0]          jtag_pins = 4'h0;
   logic [3:0]          jtag_to_test;
   logic [7:0]          rdata, page_lines, q;
   logic                rvalid, low_power, array_standby, v;
   mdp_pkg::mdp_sel_s   sel;
   mdp_pkg::mdp_pins_s  pin_out;
   mdp_pkg::mdp_pins_s  pin_oe;
   logic                one_hot;
   int                  failures = 0;
   int                  compares = 0;
   logic [15:0] sa [6] = '{16'h1fff, 16'h0000, CB, 16'h20b0, 16'h2100, 16'h20e0};
   logic [2:0]  sk [6] = '{3'b100, 3'b010, 3'b100, 3'b100, 3'b100, 3'b001};
   logic [1:0]  se [6] = '{2'b01, 2'b01, 2'b10, 2'b10, 2'b00, 2'b00};
   logic [7:0]  pv [3] = '{8'h5a, 8'hff, 8'h00};

   always #10 clk = ~clk;

   // Peripheral window and chip select share one range so both paths get exercised
   mdp_decode #(.PERIPH_EN(2'b01), .PERIPH_BASE(32'h0000_3000), .PERIPH_LIMIT(32'h0000_30ff),
      .EXT_CS_EN(2'b01), .EXT_CS_BASE(32'h0000_3000), .EXT_CS_LIMIT(32'h0000_30ff))
   u_dut (.clk(clk), .rst(rst), .bus(bus), .pin_in(pin_in),
      .jtag_pins(jtag_pins), .jtag_to_test(jtag_to_test), .rdata(rdata),
      .rvalid(rvalid), .sel(sel), .pin_out(pin_out), .pin_oe(pin_oe), .page_lines(page_lines),
      .low_power(low_power), .array_standby(array_standby));

   mdp_cpu_model u_cpu (.clk(clk), .bus(bus), .rdata(rdata), .rvalid(rvalid));

   task automatic stop_test();
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK("page_reset", 8'h00, page_lines)
      `CHK("lowpwr_reset", 1'b0, low_power)
   endtask

   // Generous bound; the sequence needs well under a thousand cycles
   initial begin
      #(20 * 5000);
      failures++;
      stop_test();
   end

   initial begin
      do_reset();
      foreach (pv[i]) begin
         u_cpu.wr_rd(CB + 16'h00e0, pv[i], q, v);
         `CHK("page_valid", 1'b1, v)
         `CHK("page_read", pv[i], q)
         `CHK("page_lines", pv[i], page_lines)
      end
      foreach (sa[i]) begin
         u_cpu.put(sa[i], 8'h00, sk[i][2], sk[i][1], sk[i][0]);
         #1;
         `CHK("ctrl_sram", se[i], {sel.ctrl_window_select, sel.sram_select})
         one_hot = $onehot0({sel.main_sector_selects, sel.secondary_sector_selects,
                             sel.sram_select, sel.ctrl_window_select});
         `CHK("one_select", 1'b1, one_hot)
         u_cpu.rel();
      end
      repeat (3) @(posedge clk);
      #1;
      `CHK("standby_fast", 1'b0, array_standby)
      u_cpu.wr(CB + 16'h00b0, 8'h02);
      #1;
      `CHK("lowpwr_set", 1'b1, low_power)
      repeat (3) @(posedge clk);
      #1;
      `CHK("standby_idle", 1'b1, array_standby)
      @(posedge clk);
      pin_in.a <= 8'h96;
      repeat (3) @(posedge clk);
      u_cpu.rd(CB + 16'h0000, q, v);
      `CHK("in_a", 8'h96, q)
      u_cpu.rd(CB + 16'h000a, q, v);
      `CHK("imc_a", 8'h96, q)
      u_cpu.wr_rd(CB + 16'h0020, 8'hc3, q, v);
      `CHK("omc_low", 8'hc3, q)
      u_cpu.wr_rd(CB + 16'h0021, 8'h3c, q, v);
      `CHK("omc_high", 8'h3c, q)
      u_cpu.put(16'h3000, 8'ha5, 1'b0, 1'b1, 1'b0);
      #1;
      `CHK("periph_sel", 1'b1, sel.peripheral_window_select_0)
      `CHK("ext_cs", 2'b01, sel.ext_chip_select)
      u_cpu.rel();
      #1;
      `CHK("repeat_out", 8'ha5, pin_out.a)
      `CHK("repeat_oe", 8'hff, pin_oe.a)
      `CHK("ext_cs_pin", 2'b01, pin_out.d)
      u_cpu.rd(16'h3000, q, v);
      `CHK("repeat_valid", 1'b1, v)
      `CHK("repeat_read", 8'h96, q)
      @(posedge clk);
      jtag_pins <= 4'h9;
      #1;
      `CHK("jtag", 4'h9, jtag_to_test)
      // Second reset in mid-run with page and power bits set
      u_cpu.wr(CB + 16'h00e0, 8'h77);
      do_reset();
      stop_test();
   end
endmodule
`default_nettype wire
